/* core/ffbuf_pkg.sv */
package ffbuf_pkg;
  localparam int PIX_W = 8;
  localparam int LINE_DEPTH = 910;
  localparam int ADDR_W = 10;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 10'h000;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 10'h001;
  localparam logic [ADDR_W-1:0] ADDR_LAST = 10'h38D;
  localparam logic [PIX_W-1:0] PIX_ZERO = 8'h00;
  localparam int N_BUF = 3;
  localparam int BUF_MAIN = 0;
  localparam int BUF_ABOVE = 1;
  localparam int BUF_BELOW = 2;
  localparam logic [1:0] PHASE_ZERO = 2'h0;
  localparam logic [1:0] PHASE_ONE = 2'h1;
  localparam real TV_LINE_KHZ = 15.734;
  localparam real VGA_LINE_KHZ = 31.468;
  localparam real VGA_LINE_US = 31.778;
  localparam real TV_LINE_US = 63.557;
  localparam int READ_DIV = 2;
  localparam logic [7:0] DAC_ADDR_ZERO = 8'h00;
endpackage

/* core/line_mem.sv */
`timescale 1ns/1ps
module line_mem (
  input  wire logic                          clock,
  input  wire logic                          ce,
  input  wire logic                          we,
  input  wire logic [ffbuf_pkg::ADDR_W-1:0]  waddr,
  input  wire logic [ffbuf_pkg::PIX_W-1:0]   wdata,
  input  wire logic                          re,
  input  wire logic [ffbuf_pkg::ADDR_W-1:0]  raddr,
  output logic      [ffbuf_pkg::PIX_W-1:0]   rdata
);
  logic [ffbuf_pkg::PIX_W-1:0] mem [ffbuf_pkg::LINE_DEPTH];

  always_ff @(posedge clock) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (ce && re) begin
      rdata <= mem[raddr];
    end
  end
endmodule

/* core/flicker_filter_line_buffer_ctrl.sv */
`timescale 1ns/1ps
module flicker_filter_line_buffer_ctrl (
  input  wire logic                        clock,
  input  wire logic                        rst,
  input  wire logic                        ce,
  input  wire logic                        vga_line_sync,
  input  wire logic [ffbuf_pkg::PIX_W-1:0] pixel_in,
  input  wire logic                        dac_write_n,
  input  wire logic                        dac_read_n,
  input  wire logic [7:0]                  dac_addr,
  input  wire logic [ffbuf_pkg::PIX_W-1:0] dac_data,
  output logic                             tv_rate_line_sync,
  output logic                             write_en_main_n,
  output logic                             write_en_above_n,
  output logic                             write_en_below_n,
  output logic                             ptr_reset_n,
  output logic                             read_clk_en,
  output logic [ffbuf_pkg::PIX_W-1:0]      pix_main,
  output logic [ffbuf_pkg::PIX_W-1:0]      pix_above,
  output logic [ffbuf_pkg::PIX_W-1:0]      pix_below,
  output logic                             shadow_dac_write,
  output logic                             shadow_dac_read_n,
  output logic [7:0]                       shadow_dac_addr,
  output logic [ffbuf_pkg::PIX_W-1:0]      shadow_dac_data
);
  // The order walks main, above, main, below; one state bit changes per
  // step.
  typedef enum logic [1:0] {
    LN_MAIN_A  = 2'b00,
    LN_ABOVE   = 2'b01,
    LN_MAIN_B  = 2'b11,
    LN_BELOW   = 2'b10
  } line_state_t;

  // Pointers stop at the last location instead of wrapping, so an
  // overlong line only rewrites that one location.
  function automatic logic [ffbuf_pkg::ADDR_W-1:0] ptr_step(
    input logic [ffbuf_pkg::ADDR_W-1:0] p
  );
    ptr_step = (p == ffbuf_pkg::ADDR_LAST) ? p : p + ffbuf_pkg::ADDR_ONE;
  endfunction

  // Gives the buffer that takes the line after the given one.
  function automatic line_state_t next_line(input line_state_t s);
    case (s)
      LN_MAIN_A: next_line = LN_ABOVE;
      LN_ABOVE:  next_line = LN_MAIN_B;
      LN_MAIN_B: next_line = LN_BELOW;
      LN_BELOW:  next_line = LN_MAIN_A;
      default:   next_line = LN_MAIN_A;
    endcase
  endfunction

  // Selects the one memory whose active-low write enable is asserted.
  function automatic logic [2:0] wen_for(input line_state_t s);
    case (s)
      LN_ABOVE: wen_for = 3'b101;
      LN_BELOW: wen_for = 3'b011;
      default:  wen_for = 3'b110;
    endcase
  endfunction

  line_state_t                      state_ff, nxt_state;
  logic                             sync_d_ff, nxt_sync_d;
  logic                             tv_sync_ff, nxt_tv_sync;
  logic [2:0]                       wen_n_ff, nxt_wen_n;
  logic                             prst_n_ff, nxt_prst_n;
  logic                             rphase_ff, nxt_rphase;
  logic [ffbuf_pkg::ADDR_W-1:0]     wptr_ff, nxt_wptr;
  logic [ffbuf_pkg::ADDR_W-1:0]     rptr_ff, nxt_rptr;
  logic [ffbuf_pkg::PIX_W-1:0]      pix_d_ff, nxt_pix_d;
  logic                             dwr_ff, nxt_dwr;
  logic [7:0]                       daddr_ff, nxt_daddr;
  logic [ffbuf_pkg::PIX_W-1:0]      ddata_ff, nxt_ddata;
  logic                             line_start;
  logic                             rdoff_ff, nxt_rdoff;
  logic [ffbuf_pkg::PIX_W-1:0]      rd [ffbuf_pkg::N_BUF];

  // A line starts on the rising edge of the source line sync.
  assign line_start = vga_line_sync && !sync_d_ff;

  // Line sequencing: each line start advances the buffer order, toggles the
  // tv-rate sync and hands the write enable to exactly one memory.
  always_comb begin
    nxt_state   = state_ff;
    nxt_sync_d  = vga_line_sync;
    nxt_tv_sync = tv_sync_ff;
    nxt_wen_n   = wen_n_ff;
    nxt_prst_n  = 1'b1;
    if (line_start) begin
      nxt_state   = next_line(state_ff);
      nxt_tv_sync = ~tv_sync_ff;
      nxt_prst_n  = 1'b0;
      nxt_wen_n   = wen_for(next_line(state_ff));
    end
  end

  // All state holds still while the clock enable is low.
  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff   <= LN_BELOW;
      sync_d_ff  <= 1'b0;
      tv_sync_ff <= 1'b0;
      wen_n_ff   <= 3'b111;
      prst_n_ff  <= 1'b1;
    end else if (ce) begin
      state_ff   <= nxt_state;
      sync_d_ff  <= nxt_sync_d;
      tv_sync_ff <= nxt_tv_sync;
      wen_n_ff   <= nxt_wen_n;
      prst_n_ff  <= nxt_prst_n;
    end
  end

  // Write side: the pixel is registered once so that it lines up with the
  // registered write enable and write pointer.
  always_comb begin
    nxt_wptr  = ptr_step(wptr_ff);
    nxt_pix_d = pixel_in;
    if (line_start) begin
      nxt_wptr = ffbuf_pkg::ADDR_ZERO;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wptr_ff  <= ffbuf_pkg::ADDR_ZERO;
      pix_d_ff <= ffbuf_pkg::PIX_ZERO;
    end else if (ce) begin
      wptr_ff  <= nxt_wptr;
      pix_d_ff <= nxt_pix_d;
    end
  end

  // Read side: the phase divider runs free so that the read rate stays half
  // the write rate; only the pointer restarts with each tv-rate line.
  always_comb begin
    nxt_rphase = ~rphase_ff;
    nxt_rptr   = rphase_ff ? ptr_step(rptr_ff) : rptr_ff;
    if (line_start && !tv_sync_ff) begin
      nxt_rptr = ffbuf_pkg::ADDR_ZERO;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rphase_ff <= 1'b0;
      rptr_ff   <= ffbuf_pkg::ADDR_ZERO;
    end else if (ce) begin
      rphase_ff <= nxt_rphase;
      rptr_ff   <= nxt_rptr;
    end
  end

  // Palette mirror: every palette write is copied one cycle later, and the
  // read strobe of the copy stays inactive so it never drives the bus.
  always_comb begin
    nxt_dwr   = !dac_write_n;
    nxt_daddr = dac_addr;
    nxt_ddata = dac_data;
    nxt_rdoff = 1'b1;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      dwr_ff   <= 1'b0;
      daddr_ff <= ffbuf_pkg::DAC_ADDR_ZERO;
      ddata_ff <= ffbuf_pkg::PIX_ZERO;
      rdoff_ff <= 1'b1;
    end else if (ce) begin
      dwr_ff   <= nxt_dwr;
      daddr_ff <= nxt_daddr;
      ddata_ff <= nxt_ddata;
      rdoff_ff <= nxt_rdoff;
    end
  end

  // Three identical memories: each is written only while its enable is low,
  // and all of them are read on every read phase.
  for (genvar i = 0; i < ffbuf_pkg::N_BUF; i++) begin : g_mem
    line_mem u_mem (
      .clock (clock),
      .ce    (ce),
      .we    (!wen_n_ff[i]),
      .waddr (wptr_ff),
      .wdata (pix_d_ff),
      .re    (rphase_ff),
      .raddr (rptr_ff),
      .rdata (rd[i])
    );
  end

  // Every output is a copy of a register.
  always_comb begin
    tv_rate_line_sync = tv_sync_ff;
    write_en_main_n   = wen_n_ff[ffbuf_pkg::BUF_MAIN];
    write_en_above_n  = wen_n_ff[ffbuf_pkg::BUF_ABOVE];
    write_en_below_n  = wen_n_ff[ffbuf_pkg::BUF_BELOW];
    ptr_reset_n       = prst_n_ff;
    read_clk_en       = rphase_ff;
    pix_main          = rd[ffbuf_pkg::BUF_MAIN];
    pix_above         = rd[ffbuf_pkg::BUF_ABOVE];
    pix_below         = rd[ffbuf_pkg::BUF_BELOW];
    shadow_dac_write  = dwr_ff;
    shadow_dac_read_n = rdoff_ff;
    shadow_dac_addr   = daddr_ff;
    shadow_dac_data   = ddata_ff;
  end
endmodule

/* bench/ffbuf_assertions.sv */
`timescale 1ns/1ps
module ffbuf_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic vga_line_sync,
  input wire logic tv_rate_line_sync,
  input wire logic write_en_main_n,
  input wire logic write_en_above_n,
  input wire logic write_en_below_n,
  input wire logic ptr_reset_n,
  input wire logic read_clk_en,
  input wire logic dac_write_n,
  input wire logic shadow_dac_write,
  input wire logic shadow_dac_read_n
);
  logic       ls_ff;
  logic       st;
  logic [2:0] en_n;
  assign en_n = {write_en_main_n, write_en_above_n, write_en_below_n};
  assign st = ce && vga_line_sync && !ls_ff;
  always_ff @(posedge clock) if (ce) ls_ff <= vga_line_sync;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_toggle; st |=> $changed(tv_rate_line_sync); endproperty
  a_toggle: assert property (p_toggle) else $error("sync no toggle");
  property p_hold; !st |=> $stable({tv_rate_line_sync, en_n}); endproperty
  a_hold: assert property (p_hold) else $error("output moved");
  property p_one; $onehot0(~en_n); endproperty
  a_one: assert property (p_one) else $error("two enables");
  property p_some; st |=> $onehot(~en_n); endproperty
  a_some: assert property (p_some) else $error("line lost");
  property p_ptr; st |=> !ptr_reset_n ##1 ptr_reset_n; endproperty
  a_ptr: assert property (p_ptr) else $error("bad pointer reset");
  property p_main; write_en_main_n != tv_rate_line_sync; endproperty
  a_main: assert property (p_main) else $error("main enable");
  property p_rd; !$past(rst) |-> read_clk_en != $past(read_clk_en);
  endproperty
  a_rd: assert property (p_rd) else $error("read rate");
  property p_sh; 1 |=> shadow_dac_write == !$past(dac_write_n); endproperty
  a_sh: assert property (p_sh) else $error("shadow write");
  property p_rdoff; shadow_dac_read_n; endproperty
  a_rdoff: assert property (p_rdoff) else $error("shadow read");
endmodule
bind flicker_filter_line_buffer_ctrl ffbuf_checker chk (.*);

/* bench/vga_line_model.sv */
`timescale 1ns/1ps
module vga_line_model #(parameter int LINE = 40) (
  input wire logic                   clock,
  input wire logic                   rst,
  output logic                       vga_line_sync,
  output logic [ffbuf_pkg::PIX_W-1:0] pixel_in
);
  int n_ff;
  always_ff @(posedge clock)
    n_ff <= (rst || n_ff == LINE - 1) ? 0 : n_ff + 1;
  assign vga_line_sync = !rst && n_ff < 4;
  assign pixel_in = n_ff[7:0];
endmodule

/* bench/flicker_filter_line_buffer_ctrl_bench.sv */
`timescale 1ns/1ps
module flicker_filter_line_buffer_ctrl_bench;
  logic        clock, rst, vga_line_sync, dac_write_n, dac_read_n, prev;
  logic        tv_rate_line_sync, write_en_main_n, write_en_above_n;
  logic        write_en_below_n, ptr_reset_n, shadow_dac_write;
  logic        shadow_dac_read_n, read_clk_en, ptv;
  logic [7:0]  pix_main, pix_above, pix_below;
  logic [23:0] pq[$];
  int          ra, ru;
  logic [7:0]  pixel_in, dac_addr, dac_data, shadow_dac_addr, shadow_dac_data;
  logic [3:0]  lq[$];
  logic [15:0] wq[$];
  logic [31:0] w;
  integer      seed;
  int          errors, check_count, lines;
  vga_line_model #(.LINE(40)) src (.*);
  flicker_filter_line_buffer_ctrl dut (.*, .ce(1'b1));
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (!ok) begin
      errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic cmp_line(input logic [3:0] got, input logic [3:0] exp);
    chk(got === exp, "line enables");
  endtask
  task automatic cmp_dac(input logic [16:0] got, input logic [16:0] exp);
    chk(got === exp, "shadow palette");
  endtask
  task automatic cmp_pix(input logic [23:0] got, input logic [23:0] exp);
    chk(got === exp, "line data");
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    clock = 0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    prev <= vga_line_sync;
    if (!rst && vga_line_sync && !prev) begin
      lq.push_back({~lines[0], lines[0], lines[1:0] != 2'h1,
        lines[1:0] != 2'h3});
      lines++;
    end
    if (!rst && ptr_reset_n === 1'b0)
      cmp_line({tv_rate_line_sync, write_en_main_n, write_en_above_n,
        write_en_below_n}, lq.pop_front());
    if (!rst && shadow_dac_write === 1'b1)
      cmp_dac({shadow_dac_read_n, shadow_dac_addr, shadow_dac_data},
        {1'b1, wq.pop_front()});
    ptv <= tv_rate_line_sync;
    ru = (tv_rate_line_sync === 1'b1 && ptv === 1'b0) ? 0 : ra;
    if (pq.size() > 0)
      cmp_pix({pix_main, pix_above, pix_below}, pq.pop_front());
    if (!rst && read_clk_en === 1'b1) begin
      if (lines >= 5 && ru < 40) pq.push_back({3{ru[7:0]}});
      ru++;
    end
    ra = ru;
  end
  initial begin
    seed = 32'h9FC6CC6B;
    {rst, dac_write_n, dac_read_n, dac_addr, dac_data} = 19'h70000;
    repeat (8) @(posedge clock);
    rst <= 0;
    repeat (600) begin
      @(posedge clock);
      w = $random(seed);
      dac_write_n <= w[16];
      dac_read_n <= w[17];
      {dac_addr, dac_data} <= w[15:0];
      if (!w[16]) wq.push_back(w[15:0]);
    end
    @(posedge clock);
    dac_write_n <= 1'b1;
    repeat (4) @(posedge clock);
    stop_test();
  end
  initial begin
    #20000;
    errors++;
    stop_test();
  end
endmodule
